// ===== src/gfoe_consts.svh
/*
 Constants of the glitch-free output enable: counts and reset values.
 Assumes inclusion by the package and the modules of this block only.
*/
`ifndef GFOE_CONSTS_SVH
`define GFOE_CONSTS_SVH

`define GFOE_NUM_OUTPUTS     10
`define GFOE_MAX_ENABLE_CYC  2
`define GFOE_EDGE_CNT_W      2
`define GFOE_RESET_OE        1'b0
`define GFOE_RESET_LEVEL     1'b0

`endif

// ===== src/gfoe_edge_detect.sv
/*
 Falling and rising edge detector for the sampled reference clock.
 Assumes the reference is synchronous to clock, one sample per edge.
*/
`timescale 1ns/1ps
`include "gfoe_consts.svh"

module gfoe_edge_detect
(
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic ref_level,
	output logic      fall,
	output logic      rise,
	output logic      level
);

	logic prev;

	// Previous sample of the reference
	always_ff @(posedge clock)
	begin
		if (reset)
			prev <= `GFOE_RESET_LEVEL;
		else
			prev <= ref_level;
	end

	// Registered edge strobes and delayed level
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			fall  <= 1'b0;
			rise  <= 1'b0;
			level <= `GFOE_RESET_LEVEL;
		end
		else
		begin
			fall  <= prev & ~ref_level;
			rise  <= ~prev & ref_level;
			level <= ref_level;
		end
	end

endmodule : gfoe_edge_detect

// ===== src/gfoe_output_enable.sv
/*
 Glitch-free output enable of a clock fanout: gates all outputs between
 following the reference clock and high impedance, entering and leaving following only on
 falling reference edges so no shortened pulses appear.
 Four states: idle off, armed low, following, and draining until the
 reference falls; a re-enable while draining returns to following.
 A pending switch that lets two falling edges pass raises timeout.
 Assumes the reference clock and enable are sampled on clock, and that
 the testbench resolves each output pin from its enable.
*/
// What this block does
// - After enable falls, outputs go high impedance only once the next falling reference edge has occurred.
// - While enable stays low, outputs already in high impedance stay in high impedance.
// - When outputs are high impedance and enable rises, they are driven low at once with no reference clock edge needed.
// - After enable rises, outputs resume toggling after a falling reference edge, within two reference cycles.
// - With outputs off and a static reference, enable acts without the reference and a rise drives outputs low.
// - With a static reference, a falling enable does not return outputs to high impedance until a falling edge.
// - While the reference toggles, any enable or disable transition completes within two reference cycles of the enable change.
`timescale 1ns/1ps
`include "gfoe_consts.svh"

module gfoe_output_enable
#(
	parameter int NUM_OUTPUTS = `GFOE_NUM_OUTPUTS
)
(
	input  wire logic                   clock,
	input  wire logic                   reset,
	input  wire logic                   ref_clock,
	input  wire logic                   enable,
	output logic [NUM_OUTPUTS-1:0]      clk_out,
	output logic [NUM_OUTPUTS-1:0]      clk_out_en,
	output gfoe_pkg::gfoe_state_t       state,
	output logic                        timeout
);
	import gfoe_pkg::*;

	// Sampled reference, gating state and pending edge count
	logic        ref_fall;
	logic        ref_rise;
	logic        ref_level;
	gfoe_state_t next_state;
	gfoe_count_t fall_count;

	// True while a switch waits for a falling reference edge
	function automatic logic is_pending
	(
		input gfoe_state_t st
	);
		return (st == GFOE_ST_LOW) || (st == GFOE_ST_DRAIN);
	endfunction : is_pending

	// True in every state that drives the pins
	function automatic logic is_driving
	(
		input gfoe_state_t st
	);
		return st != GFOE_ST_HIZ;
	endfunction : is_driving

	// True in every state in which the pins follow the reference
	function automatic logic is_following
	(
		input gfoe_state_t st
	);
		return (st == GFOE_ST_RUN) || (st == GFOE_ST_DRAIN);
	endfunction : is_following

	// True once the pending edge count reaches its limit
	function automatic logic is_overdue
	(
		input gfoe_count_t cnt
	);
		return cnt >= gfoe_count_t'(`GFOE_MAX_ENABLE_CYC);
	endfunction : is_overdue

	// Saturating step of the edge count
	function automatic gfoe_count_t sat_inc
	(
		input gfoe_count_t cnt
	);
		return (cnt == '1) ? cnt : gfoe_count_t'(cnt + 1'b1);
	endfunction : sat_inc

	// Edge strobes of the sampled reference

	gfoe_edge_detect u_edge
	(
		.clock     (clock),
		.reset     (reset),
		.ref_level (ref_clock),
		.fall      (ref_fall),
		.rise      (ref_rise),
		.level     (ref_level)
	);

	// Gating state machine
	always_comb
	begin
		next_state = state;
		unique case (state)
			GFOE_ST_HIZ:
			begin
				// Enable acts at once, no reference edge needed
				if (enable)
				begin
					next_state = GFOE_ST_LOW;
				end
			end
			GFOE_ST_LOW:
			begin
				// Armed low: leave only on a falling reference edge
				if (ref_fall)
				begin
					next_state = enable ? GFOE_ST_RUN
						: GFOE_ST_HIZ;
				end
			end
			GFOE_ST_RUN:
			begin
				if (!enable)
				begin
					next_state = GFOE_ST_DRAIN;
				end
			end
			GFOE_ST_DRAIN:
			begin
				// Keep following until the reference falls
				if (enable)
				begin
					next_state = GFOE_ST_RUN;
				end
				else if (ref_fall)
				begin
					next_state = GFOE_ST_HIZ;
				end
			end
			default:
			begin
				next_state = GFOE_ST_HIZ;
			end
		endcase
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state <= GFOE_ST_HIZ;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Pin drive enables: off only in the idle state
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			clk_out_en <= '0;
		end
		else if (is_driving(next_state))
		begin
			clk_out_en <= '1;
		end
		else
		begin
			clk_out_en <= '0;
		end
	end

	// Pin levels: low while armed, reference while following
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			clk_out <= '0;
		end
		else if (is_following(next_state))
		begin
			clk_out <= {NUM_OUTPUTS{ref_level}};
		end
		else
		begin
			clk_out <= '0;
		end
	end

	// Falling edges seen while a switch is pending
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			fall_count <= '0;
		end
		else if (!is_pending(state))
		begin
			fall_count <= '0;
		end
		else if (ref_fall)
		begin
			fall_count <= sat_inc(fall_count);
		end
	end

	// Flags a pending switch that let the edge limit pass
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			timeout <= 1'b0;
		end
		else
		begin
			timeout <= is_overdue(fall_count);
		end
	end

endmodule : gfoe_output_enable

// ===== src/gfoe_pkg.sv
/*
 Types of the glitch-free output enable.
 Assumes the constants header is available on the include path.
*/
`include "gfoe_consts.svh"

package gfoe_pkg;

	typedef enum logic [3:0]
	{
		GFOE_ST_HIZ     = 4'b0001,
		GFOE_ST_LOW     = 4'b0010,
		GFOE_ST_RUN     = 4'b0100,
		GFOE_ST_DRAIN   = 4'b1000
	} gfoe_state_t;

	typedef logic [`GFOE_EDGE_CNT_W-1:0] gfoe_count_t;

endpackage : gfoe_pkg

// ===== tb/gfoe_output_enable_assertions.sv
/*
 Checker of the output enable ports.
 Assumes binding into gfoe_output_enable and sight of its ports only.
*/
`timescale 1ns/1ps

module gfoe_oe_chk
	import gfoe_pkg::*;
#(
	parameter int NUM_OUTPUTS = 10
)
(
	input wire logic                   clock,
	input wire logic                   reset,
	input wire logic                   ref_clock,
	input wire logic                   enable,
	input wire logic [NUM_OUTPUTS-1:0] clk_out,
	input wire logic [NUM_OUTPUTS-1:0] clk_out_en,
	input wire gfoe_state_t            state,
	input wire logic                   timeout
);
	logic      [3:0] rh = '0;
	wire logic [3:0] fl = rh & ~{rh[2:0], ref_clock};

	always_ff @(posedge clock)
		rh <= {rh[2:0], ref_clock};

	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	a_hold_hiz: assert property (!enable && clk_out_en == 0 |=>
		clk_out_en == 0) else $error("outputs left hiz");
	a_on_low: assert property (enable && clk_out_en == 0 |=>
		clk_out_en == '1 && clk_out == 0) else $error("no low drive");
	a_static_on: assert property (enable && clk_out_en == 0 &&
		$stable(ref_clock) |=> clk_out == 0) else $error("static on");
	a_off_edge: assert property (state == GFOE_ST_DRAIN &&
		$fell(ref_clock) |-> ##[1:4] (clk_out_en == 0 || enable))
		else $error("late hiz");
	a_off_wait: assert property (clk_out_en[0] && fl == 0 |=>
		clk_out_en[0]) else $error("hiz without fall");
	a_run_resume: assert property (state == GFOE_ST_LOW &&
		enable && $fell(ref_clock) |-> ##[1:4]
		(state == GFOE_ST_RUN || !enable)) else $error("no resume");
	a_no_stale: assert property (!timeout)
		else $error("transition too slow");
	a_same_out: assert property ((clk_out == 0 || clk_out == '1) &&
		(clk_out_en == 0 || clk_out_en == '1)) else $error("split out");

	c_run: cover property (state == GFOE_ST_RUN);
	c_off: cover property ($fell(clk_out_en[0]));
	c_on: cover property ($rose(clk_out_en[0]));
endmodule : gfoe_oe_chk

bind gfoe_output_enable gfoe_oe_chk #(.NUM_OUTPUTS(NUM_OUTPUTS)) chk_inst
	(.clock, .reset, .ref_clock, .enable, .clk_out, .clk_out_en, .state,
	.timeout);

// ===== tb/gfoe_ref_src.sv
/*
 Reference clock source in front of the output enable.
 Assumes one bench clock; the reference stands still while run is low.
*/
`timescale 1ns/1ps

module gfoe_ref_src
#(
	parameter int HALF = 3
)
(
	input  wire logic clock,
	input  wire logic run,
	output logic      ref_clock
);
	logic level = 1'b0;
	int   cnt   = 0;

	assign ref_clock = level;

	always @(posedge clock)
	begin
		if (run && cnt == HALF - 1)
			level <= ~level;
		cnt <= (!run || cnt == HALF - 1) ? 0 : cnt + 1;
	end
endmodule : gfoe_ref_src

// ===== tb/glitch_free_output_enable_tb_top.sv
/*
 Bench of the glitch-free output enable.
 Assumes a reference that toggles every three clock cycles while run.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
	err_total++; $display("[FAIL] %s exp %h got %h", n, e, a); end end

module glitch_free_output_enable_tb_top;
	import gfoe_pkg::*;
	logic        clock = 0, reset = 1, enable = 0, run = 0, ref_clock;
	logic        timeout, p;
	logic [9:0]  clk_out, clk_out_en;
	gfoe_state_t state;
	int          err_total = 0, check_count = 0, n = 0;
	// Enable, run, expected drive, expected state (zero: not checked)
	logic [6:0]  rows [6] = '{7'h74, 7'h21, 7'h01, 7'h52, 7'h10, 7'h21};

	gfoe_ref_src gfoe_ref_src_inst (.clock, .run, .ref_clock);
	gfoe_output_enable gfoe_output_enable_inst (.clock, .reset, .ref_clock,
		.enable, .clk_out, .clk_out_en, .state, .timeout);

	task automatic end_sim;
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	initial
		forever #5 clock = ~clock;

	initial
	begin
		#3000;
		err_total++;
		end_sim;
	end

	initial
	begin
		repeat (3) @(posedge clock);
		reset <= 0;
		foreach (rows[i])
		begin
			@(posedge clock);
			{enable, run} <= rows[i][6:5];
			repeat (15) @(posedge clock);
			#1;
			`CHK("oe", {10{rows[i][4]}}, clk_out_en)
			`CHK("timeout", 1'b0, timeout)
			if (rows[i][3:0] != 0)
				`CHK("state", rows[i][3:0], state)
			if (!rows[i][5])
				`CHK("out", 10'h000, clk_out)
		end
		@(posedge clock);
		enable <= 1;
		@(posedge clock);
		#1;
		`CHK("oe_now", 10'h3ff, clk_out_en)
		`CHK("low_now", 10'h000, clk_out)
		repeat (12) @(posedge clock);
		#1;
		p = clk_out[0];
		repeat (12)
		begin
			@(posedge clock);
			#1;
			n += (clk_out[0] !== p);
			p = clk_out[0];
		end
		`CHK("toggles", 4, n)
		@(posedge clock);
		reset <= 1;
		@(posedge clock);
		#1;
		`CHK("rst_oe", 10'h000, clk_out_en)
		`CHK("rst_state", GFOE_ST_HIZ, state)
		end_sim;
	end
endmodule : glitch_free_output_enable_tb_top
